// ---- include/vdbs_defs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef VDBS_DEFS_SVH
`define VDBS_DEFS_SVH

// register indices; byte address is four times the index
`define VDBS_IDX_CFG0 6'h00
`define VDBS_IDX_VCO_SRC 6'h07
`define VDBS_IDX_LOCK_FN 6'h0E
`define VDBS_IDX_PLL_DIV 6'h0F
`define VDBS_IDX_STATE 6'h10
`define VDBS_IDX_IRQ_STAT 6'h11
`define VDBS_IDX_IRQ_MASK 6'h12

// cfg0 fields
`define VDBS_CFG0_RESET_BIT 31
`define VDBS_CFG0_CALFLAG_BIT 28
`define VDBS_CFG0_ZERO_DLY_BIT 27

// vco source field and codes
`define VDBS_VCO_SRC_LSB 25
`define VDBS_VCO_SRC_MSB 26
`define VDBS_VCO_SRC_DIVIDED 2'h0
`define VDBS_VCO_SRC_DIRECT 2'h2

// lock pin function field and codes
`define VDBS_LOCK_FN_LSB 20
`define VDBS_LOCK_FN_MSB 23
`define VDBS_LOCK_FN_ACT_HIGH 4'h3
`define VDBS_LOCK_FN_ACT_LOW 4'h4

// pll divide fields
`define VDBS_CP_GAIN_LSB 30
`define VDBS_CP_GAIN_MSB 31
`define VDBS_VCO_DIV_LSB 26
`define VDBS_VCO_DIV_MSB 29
`define VDBS_FB_CNT_LSB 8
`define VDBS_FB_CNT_MSB 25

// reset values
`define VDBS_RST_CFG0 32'h0000_0000
`define VDBS_RST_VCO_SRC 32'h0000_0000
`define VDBS_RST_LOCK_FN 32'h0000_0000
`define VDBS_RST_PLL_DIV 32'h0800_0000
`define VDBS_RST_IRQ_MASK 3'h0

// interrupt status bits
`define VDBS_IRQ_CAL_DONE 0
`define VDBS_IRQ_LOCK_GAIN 1
`define VDBS_IRQ_LOCK_LOSS 2

// timing
`define VDBS_CLK_MHZ 50
`define VDBS_CAL_TIME_US 2000
`define VDBS_CAL_CYCLES (`VDBS_CAL_TIME_US * `VDBS_CLK_MHZ)

`endif

// ---- include/vdbs_pkg.sv ----
// types shared by the sequencer modules
package vdbs_pkg;
    typedef enum logic {vdbs_cal_idle, vdbs_cal_run} vdbs_cal_state_e;
    typedef logic [31:0] vdbs_word_t;
    typedef logic [7:0] vdbs_addr_t;
endpackage

// ---- include/vdbs_cal_if.sv ----
// handshake between the register logic and the calibration engine
`timescale 1ns/1ps
interface vdbs_cal_if;
    logic start;
    logic abort;
    logic busy;
    logic done;
    modport engine (input start, input abort, output busy, output done);
    modport ctrl (output start, output abort, input busy, input done);
endinterface // vdbs_cal_if

// ---- rtl/vdbs_cal_engine.sv ----
// frequency calibration timer: busy from start until the run time elapses or an abort arrives
`timescale 1ns/1ps
`include "vdbs_defs.svh"
module vdbs_cal_engine #(
    parameter int CAL_CYCLES = `VDBS_CAL_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control handshake
    vdbs_cal_if.engine cal
);
    import vdbs_pkg::*;

    localparam int CW = $clog2(CAL_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CAL_CYCLES - 1);

    vdbs_cal_state_e state;
    vdbs_cal_state_e next_state;
    logic [CW-1:0] count;
    logic busy_q;
    logic done_q;
    wire at_end = (count == LAST);

    // ----------------------------------------
    // state
    // ----------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            vdbs_cal_idle: if (cal.start) next_state = vdbs_cal_run;
            vdbs_cal_run: if (cal.abort || at_end) next_state = vdbs_cal_idle;
        endcase
    end

    // a restart while running begins the count again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= vdbs_cal_idle;
            count <= '0;
            done_q <= 1'b0;
        end else begin
            state <= cal.start ? vdbs_cal_run : next_state;
            count <= (cal.start || state == vdbs_cal_idle) ? '0 : count + 1'b1;
            done_q <= (state == vdbs_cal_run) && at_end && !cal.abort
                      && !cal.start;
        end
    end

    assign busy_q = (state == vdbs_cal_run);
    assign cal.busy = busy_q;
    assign cal.done = done_q;
endmodule // vdbs_cal_engine

// ---- rtl/vdbs_top.sv ----
// divider-bypass configuration logic of the clock conditioner
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "vdbs_defs.svh"

module vdbs_top #(
    parameter int CAL_CYCLES = `VDBS_CAL_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire vdbs_pkg::vdbs_addr_t paddr,
    input wire vdbs_pkg::vdbs_word_t pwdata,
    output vdbs_pkg::vdbs_word_t prdata,
    output logic pready,
    output logic pslverr,
    // analog loop status, asynchronous
    input wire logic pll_lock_raw,
    // device outputs
    output logic lock_indicator_pin,
    output logic cal_running,
    output logic [3:0] dist_divide,
    output logic [17:0] feedback_count,
    output logic [1:0] charge_pump_gain,
    output logic irq
);
    import vdbs_pkg::*;

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    vdbs_word_t cfg0;
    vdbs_word_t vco_src_reg;
    vdbs_word_t lock_fn_reg;
    vdbs_word_t pll_div_reg;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;

    vdbs_cal_if cal_if ();

    vdbs_cal_engine #(
        .CAL_CYCLES(CAL_CYCLES)
    ) u_cal (
        .pclk(pclk),
        .presetn(presetn),
        .cal(cal_if.engine)
    );

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    // one wait state so that read data comes from a flip-flop
    // no byte strobes: every write to a configuration register replaces the whole word
    wire access = psel && penable;
    wire commit = access && pready;
    wire wr_en = commit && pwrite;
    wire [5:0] idx = paddr[7:2];
    wire aligned = (paddr[1:0] == 2'b00);
    wire hit_cfg0 = aligned && (idx == `VDBS_IDX_CFG0);
    wire hit_vco = aligned && (idx == `VDBS_IDX_VCO_SRC);
    wire hit_lock = aligned && (idx == `VDBS_IDX_LOCK_FN);
    wire hit_div = aligned && (idx == `VDBS_IDX_PLL_DIV);
    wire hit_state = aligned && (idx == `VDBS_IDX_STATE);
    wire hit_istat = aligned && (idx == `VDBS_IDX_IRQ_STAT);
    wire hit_imask = aligned && (idx == `VDBS_IDX_IRQ_MASK);
    wire mapped = hit_cfg0 || hit_vco || hit_lock || hit_div
                  || hit_state || hit_istat || hit_imask;

    wire wr_cfg0 = wr_en && hit_cfg0;
    wire wr_vco = wr_en && hit_vco;
    wire wr_lock = wr_en && hit_lock;
    wire wr_div = wr_en && hit_div;
    wire wr_istat = wr_en && hit_istat;
    wire wr_imask = wr_en && hit_imask;

    // reset bit wins over the rest of the same word
    wire soft_reset = wr_cfg0 && pwdata[`VDBS_CFG0_RESET_BIT];

    // ----------------------------------------
    // field views
    // ----------------------------------------
    // stored settings except new_src, which is the write data; a write shows here one cycle later
    wire zero_dly = cfg0[`VDBS_CFG0_ZERO_DLY_BIT];
    wire cal_done_on_lock_flag = cfg0[`VDBS_CFG0_CALFLAG_BIT];
    wire [1:0] vco_src = vco_src_reg[`VDBS_VCO_SRC_MSB:`VDBS_VCO_SRC_LSB];
    wire [3:0] lock_fn = lock_fn_reg[`VDBS_LOCK_FN_MSB:`VDBS_LOCK_FN_LSB];
    wire [3:0] vco_div = pll_div_reg[`VDBS_VCO_DIV_MSB:`VDBS_VCO_DIV_LSB];
    wire [1:0] new_src = pwdata[`VDBS_VCO_SRC_MSB:`VDBS_VCO_SRC_LSB];
    wire [1:0] next_gain = pll_div_reg[`VDBS_CP_GAIN_MSB:`VDBS_CP_GAIN_LSB];
    wire [17:0] next_fb = pll_div_reg[`VDBS_FB_CNT_MSB:`VDBS_FB_CNT_LSB];

    // zero-delay must be sampled as stored, before this write lands
    wire cal_start = wr_div && !zero_dly;
    assign cal_if.start = cal_start;
    assign cal_if.abort = soft_reset;

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    // the reset bit acts once and is never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg0 <= `VDBS_RST_CFG0;
        end else if (soft_reset) begin
            cfg0 <= `VDBS_RST_CFG0;
        end else if (wr_cfg0) begin
            cfg0 <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_src_reg <= `VDBS_RST_VCO_SRC;
            lock_fn_reg <= `VDBS_RST_LOCK_FN;
            pll_div_reg <= `VDBS_RST_PLL_DIV;
        end else if (soft_reset) begin
            vco_src_reg <= `VDBS_RST_VCO_SRC;
            lock_fn_reg <= `VDBS_RST_LOCK_FN;
            pll_div_reg <= `VDBS_RST_PLL_DIV;
        end else begin
            if (wr_vco) vco_src_reg <= pwdata;
            if (wr_lock) lock_fn_reg <= pwdata;
            if (wr_div) pll_div_reg <= pwdata;
        end
    end

    // ----------------------------------------
    // feedback path validity
    // ----------------------------------------
    // switching to the raw vco leaves the old count wrong by the
    // vco divide, so lock is withheld until a new count arrives
    logic loop_ok;
    wire go_direct = wr_vco && (new_src == `VDBS_VCO_SRC_DIRECT)
                     && (vco_src != `VDBS_VCO_SRC_DIRECT);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_ok <= 1'b1;
        end else if (soft_reset || wr_div) begin
            loop_ok <= 1'b1;
        end else if (go_direct) begin
            loop_ok <= 1'b0;
        end
    end

    // ----------------------------------------
    // lock input synchroniser
    // ----------------------------------------
    // stage one may settle late; only stages two and three are trusted
    // a change is taken once both agree, so a short glitch is dropped
    logic [2:0] lock_sync;
    logic lock_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_sync <= 3'h0;
            lock_q <= 1'b0;
        end else begin
            lock_sync <= {lock_sync[1:0], pll_lock_raw};
            if (lock_sync[1] == lock_sync[2]) lock_q <= lock_sync[2];
        end
    end

    // ----------------------------------------
    // calibration done and lock state
    // ----------------------------------------
    // done beats a new start or reset bit in one cycle
    logic cal_done_seen;
    logic locked;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_done_seen <= 1'b0;
        end else if (cal_if.done) begin
            cal_done_seen <= 1'b1;
        end else if (cal_start || soft_reset) begin
            cal_done_seen <= 1'b0;
        end
    end

    // locked and the pin add two stages after the synchroniser
    // a running calibration keeps the loop from counting as locked
    wire next_locked = lock_q && loop_ok && !cal_if.busy;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked <= 1'b0;
        end else begin
            locked <= next_locked;
        end
    end

    // ----------------------------------------
    // lock indicator pin
    // ----------------------------------------
    // the calibration meaning only holds while zero-delay is clear
    wire cal_meaning = cal_done_on_lock_flag && !zero_dly;
    wire indication = cal_meaning ? cal_done_seen : locked;
    wire pin_act_high = (lock_fn == `VDBS_LOCK_FN_ACT_HIGH);
    wire pin_act_low = (lock_fn == `VDBS_LOCK_FN_ACT_LOW);
    wire next_pin = pin_act_high ? indication
                    : pin_act_low ? !indication : 1'b0;

    // ----------------------------------------
    // distribution divide
    // ----------------------------------------
    // with the divider in the path the channels run at vco/div
    wire [3:0] next_dist = (vco_src == `VDBS_VCO_SRC_DIRECT)
                           ? 4'h1 : vco_div;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_indicator_pin <= 1'b0;
            cal_running <= 1'b0;
            dist_divide <= 4'h0;
            feedback_count <= 18'h0;
            charge_pump_gain <= 2'h0;
        end else begin
            lock_indicator_pin <= next_pin;
            cal_running <= cal_if.busy;
            dist_divide <= next_dist;
            feedback_count <= next_fb;
            charge_pump_gain <= next_gain;
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    // both lock flops reset low, so no false edge follows reset
    logic locked_d;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_d <= 1'b0;
        end else begin
            locked_d <= locked;
        end
    end

    wire [2:0] irq_events = {locked_d && !locked, locked && !locked_d,
                             cal_if.done};
    wire [2:0] irq_clear = wr_istat ? pwdata[2:0] : 3'h0;
    // an event in the clearing cycle survives the clear
    wire [2:0] next_irq_stat = (irq_stat & ~irq_clear) | irq_events;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= 3'h0;
            irq_mask <= `VDBS_RST_IRQ_MASK;
            irq <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            if (wr_imask) irq_mask <= pwdata[2:0];
            irq <= |(next_irq_stat & (wr_imask ? pwdata[2:0] : irq_mask));
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // unmapped or unaligned reads return zero with an error
    wire [31:0] state_word = {28'h0, loop_ok, locked, cal_done_seen,
                              cal_if.busy};
    wire [31:0] rd_mux = hit_cfg0 ? cfg0
                       : hit_vco ? vco_src_reg
                       : hit_lock ? lock_fn_reg
                       : hit_div ? pll_div_reg
                       : hit_state ? state_word
                       : hit_istat ? {29'h0, irq_stat}
                       : hit_imask ? {29'h0, irq_mask}
                       : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= access && !pready;
            pslverr <= access && !pready && !mapped;
            if (access && !pready && !pwrite) prdata <= rd_mux;
        end
    end
endmodule // vdbs_top

// ---- testbench/vdbs_host.sv ----
// host model: apb master issuing one register transfer at a time
`timescale 1ns/1ps
module vdbs_host (
    // clock
    input wire logic pclk,
    // apb master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output vdbs_pkg::vdbs_addr_t paddr,
    output vdbs_pkg::vdbs_word_t pwdata,
    input wire vdbs_pkg::vdbs_word_t prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import vdbs_pkg::*;
    int n_to = 0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // ------------------------------
    // one transfer, entered just after a rising edge
    // ------------------------------
    task automatic xfer(input logic w, input vdbs_addr_t a,
                        input vdbs_word_t d, output vdbs_word_t q,
                        output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_to++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show the inverse, not a stale copy
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask
endmodule // vdbs_host

// ---- testbench/vdbs_top_props.sv ----
// concurrent checks on the divider-bypass logic ports
`timescale 1ns/1ps
module vdbs_top_props #(
    parameter int CAL_CYCLES = 100000
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire vdbs_pkg::vdbs_addr_t paddr,
    input wire vdbs_pkg::vdbs_word_t pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // device side
    input wire logic pll_lock_raw,
    input wire logic lock_indicator_pin,
    input wire logic cal_running,
    input wire logic [3:0] dist_divide,
    input wire logic [17:0] feedback_count,
    input wire logic [1:0] charge_pump_gain
);
    import vdbs_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------
    // shadow of the settings the checks depend on
    // ------------------------------
    logic zd, flag, src2;
    logic [3:0] fn;
    logic [23:0] pd_q;
    wire wr = psel && penable && pwrite && pready && !pslverr;
    wire wr_cfg = wr && paddr == 8'h00;
    wire wr_src = wr && paddr == 8'h1C;
    wire wr_fn = wr && paddr == 8'h38;
    wire wr_div = wr && paddr == 8'h3C;
    wire clr = wr_cfg && pwdata[31];
    wire to_direct = wr_src && pwdata[26:25] == 2'h2;
    // pin follows plain loop lock
    wire ind_lock = fn == 4'h3 && (zd || !flag);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zd <= 1'b0;
            flag <= 1'b0;
            src2 <= 1'b0;
            fn <= 4'h0;
        end else begin
            if (wr_cfg) zd <= pwdata[27] && !clr;
            if (wr_cfg) flag <= pwdata[28] && !clr;
            if (wr_src || clr) src2 <= to_direct;
            if (wr_fn || clr) fn <= clr ? 4'h0 : pwdata[23:20];
        end
    end
    always_ff @(posedge pclk) begin
        if (wr_div) pd_q <= pwdata[31:8];
    end
    sequence s_div_free;
        wr_div && !zd;
    endsequence
    sequence s_div_held;
        wr_div && zd && !cal_running;
    endsequence
    sequence s_lose;
        to_direct && !src2 && ind_lock;
    endsequence
    apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("ready not in second access cycle");
    cal_start_a: assert property (s_div_free |-> ##[1:3] cal_running)
        else $error("calibration did not start");
    cal_held_a: assert property (s_div_held |=> !cal_running [*4])
        else $error("calibration ran with zero delay set");
    reset_bit_a: assert property (clr |->
        ##[1:3] (!cal_running && dist_divide == 4'h2))
        else $error("reset bit did not restore defaults");
    direct_div_a: assert property (to_direct |->
        ##[1:2] dist_divide == 4'h1)
        else $error("direct vco not reflected");
    lock_loss_a: assert property (s_lose |->
        ##[1:6] !lock_indicator_pin)
        else $error("lock kept after divider bypass");
    lock_show_a: assert property (
        (ind_lock && !pll_lock_raw) [*8] |-> !lock_indicator_pin)
        else $error("pin shows lock without loop lock");
    pin_off_a: assert property ((fn != 4'h3 && fn != 4'h4) [*3]
        |-> !lock_indicator_pin)
        else $error("pin driven for non lock code");
    div_out_a: assert property (wr_div |-> ##2
        (feedback_count == pd_q[17:0]
        && charge_pump_gain == pd_q[23:22]
        && (src2 || dist_divide == pd_q[21:18])))
        else $error("divider outputs do not follow write");
endmodule // vdbs_top_props
bind vdbs_top vdbs_top_props #(.CAL_CYCLES(CAL_CYCLES)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .pll_lock_raw(pll_lock_raw),
    .lock_indicator_pin(lock_indicator_pin), .cal_running(cal_running),
    .dist_divide(dist_divide), .feedback_count(feedback_count),
    .charge_pump_gain(charge_pump_gain));

// ---- testbench/vdbs_top_test.sv ----
// self-checking bench for the divider-bypass configuration logic
`timescale 1ns/1ps
module vdbs_top_test;
    import vdbs_pkg::*;
    localparam int CAL = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic pll_lock_raw = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, lock_pin, cal_run, irq;
    vdbs_addr_t paddr;
    vdbs_word_t pwdata, prdata, q;
    logic [3:0] dist_divide;
    logic [17:0] feedback_count;
    logic [1:0] gain;
    logic e;
    logic [31:0] m [logic [7:0]];
    int n_errors = 0;
    int checks = 0;
    integer seed = 32'hACD0BB86;
    int vdiv, fb, g;
    int codes [3] = '{4, 5, 3};
    always #10 pclk = ~pclk;
    vdbs_top #(.CAL_CYCLES(CAL)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pll_lock_raw(pll_lock_raw),
        .lock_indicator_pin(lock_pin), .cal_running(cal_run),
        .dist_divide(dist_divide), .feedback_count(feedback_count),
        .charge_pump_gain(gain), .irq(irq));
    vdbs_host host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    // ------------------------------
    // compare, model and bus helpers
    // ------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] msk(input logic [7:0] a);
        case (a)
            8'h00: return 32'h7FFF_FFFF;
            8'h1C: return 32'h0600_0000;
            8'h38: return 32'h00F0_0000;
            8'h3C: return 32'hFFFF_FF00;
            8'h48: return 32'h0000_0007;
            default: return 32'h0;
        endcase
    endfunction
    function automatic logic bad(input logic [7:0] a);
        return !(a inside {8'h00, 8'h1C, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h48});
    endfunction
    task automatic rst_cfg();
        m[8'h00] = 32'h0;
        m[8'h1C] = 32'h0;
        m[8'h38] = 32'h0;
        m[8'h3C] = 32'h0800_0000;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q, e);
        chk(e, bad(a));
        if (a == 8'h00 && d[31]) rst_cfg();
        else if (msk(a) != 0) m[a] = d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] mk,
                      input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, q, e);
        chk(e, bad(a));
        chk(q & mk, exp & mk);
    endtask
    task automatic rdall();
        foreach (m[a]) rd(a, msk(a), m[a]);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic wait_pin(input logic v, input int lim);
        int n;
        n = 0;
        while (lock_pin !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk(lock_pin, v);
    endtask
    task automatic conclude();
        n_errors = n_errors + host.n_to;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ------------------------------
    // stage one, stage two, lock codes
    // ------------------------------
    initial begin
        tick(4);
        presetn <= 1'b1;
        pll_lock_raw <= 1'b1;
        tick(1);
        rst_cfg();
        m[8'h48] = 32'h0;
        rdall();
        chk(dist_divide, 4'h2);
        rd(8'h4C, 32'hFFFF_FFFF, 32'h0);
        wr(8'h02, 32'hFFFF_FFFF);
        wr(8'h3C, $random(seed));
        wr(8'h00, 32'h8000_0000 | $random(seed));
        tick(1);
        chk(cal_run, 1'b0);
        rdall();
        wr(8'h00, 32'h1000_0000);
        wr(8'h1C, 32'h0);
        wr(8'h38, 32'h0030_0000);
        wr(8'h48, 32'h7);
        wr(8'h44, 32'h7);
        vdiv = 2 + {$random(seed)} % 7;
        fb = 1 + {$random(seed)} % 4000;
        g = {$random(seed)} % 4;
        wr(8'h3C, (g << 30) | (vdiv << 26) | (fb << 8));
        tick(1);
        chk(cal_run, 1'b1);
        chk(dist_divide, vdiv);
        wait_pin(1'b1, CAL + 40);
        chk(cal_run, 1'b0);
        chk(irq, 1'b1);
        rd(8'h44, 32'h1, 32'h1);
        wr(8'h48, 32'h0);
        chk(irq, 1'b0);
        wr(8'h44, 32'h7);
        wr(8'h48, 32'h7);
        rd(8'h44, 32'h7, 32'h0);
        wr(8'h00, 32'h0800_0000);
        chk(lock_pin, 1'b1);
        wr(8'h1C, 32'h0400_0000);
        tick(1);
        chk(dist_divide, 4'h1);
        wait_pin(1'b0, 10);
        wr(8'h38, 32'h0030_0000);
        wr(8'h3C, (g << 30) | (vdiv << 26) | (fb * vdiv << 8));
        rd(8'h40, 32'h9, 32'h8);
        chk(cal_run, 1'b0);
        wr(8'h00, 32'h0);
        wait_pin(1'b1, 12);
        chk(feedback_count, fb * vdiv);
        chk(gain, g);
        chk(irq, 1'b1);
        rd(8'h44, 32'h6, 32'h6);
        foreach (codes[i]) begin
            wr(8'h38, codes[i] << 20);
            tick(3);
            chk(lock_pin, codes[i] == 3);
        end
        rdall();
        pll_lock_raw <= 1'b0;
        wait_pin(1'b0, 12);
        tick(10);
        conclude();
    end
    initial begin
        tick(20000);
        n_errors++;
        conclude();
    end
endmodule // vdbs_top_test
